// ---- include/pimd_pkg.sv ----
// shared constants, types and lookups of the prioritized interrupt and micro dma block
package pimd_pkg;
  localparam int NCH = 11;                   // channel count, index 0 is highest priority
  localparam int NMSK = 8;                   // maskable channels
  localparam int NDMA = 4;                   // micro dma capable channels
  localparam logic [3:0] CH_SWI  = 4'h0;
  localparam logic [3:0] CH_NMI  = 4'h1;
  localparam logic [3:0] CH_WD   = 4'h2;
  localparam logic [3:0] CH_EXT0 = 4'h3;
  localparam logic [3:0] CH_T0   = 4'h4;
  localparam logic [3:0] CH_T1   = 4'h5;
  localparam logic [3:0] CH_EXT1 = 4'h8;
  localparam logic [3:0] CH_RX   = 4'h9;
  localparam logic [3:0] CH_TX   = 4'hA;
  localparam int IFF_BIT = 5;                // enable flip-flop position in the flag byte
  localparam logic [15:0] RAM_BASE = 16'hFF00;
  // parameter block layout
  localparam logic [2:0] PB_COUNT  = 3'h0;
  localparam logic [2:0] PB_DST_LO = 3'h1;
  localparam logic [2:0] PB_DST_HI = 3'h2;
  localparam logic [2:0] PB_SRC_LO = 3'h3;
  localparam logic [2:0] PB_SRC_HI = 3'h4;
  localparam logic [2:0] PB_MODE   = 3'h5;
  localparam int PB_BYTES = 6;
  localparam int MODE_LEN_BIT = 2;
  localparam logic [1:0] UPD_FIX  = 2'h0;
  localparam logic [1:0] UPD_DINC = 2'h1;
  localparam logic [1:0] UPD_SINC = 2'h2;
  localparam logic [1:0] UPD_SDEC = 2'h3;
  // timing
  localparam int CLK_NS = 100;
  localparam int STATE_NS = 200;
  localparam int GEN_STATES = 20;
  localparam int DMA_STATES = 46;
  localparam int STATE_CYC_I = (STATE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] STATE_CYC = 7'(STATE_CYC_I);
  localparam logic [6:0] GEN_CYC = 7'(GEN_STATES * STATE_CYC_I);
  localparam logic [6:0] DMA_CYC = 7'(DMA_STATES * STATE_CYC_I);
  // micro dma sequence: six parameter reads, four move steps, five write-backs
  localparam logic [3:0] OP_MOVE = 4'h6;
  localparam logic [3:0] OP_WBACK = 4'hA;
  localparam logic [3:0] OP_LAST = 4'hE;
  localparam logic [1:0] PH_LAST = 2'h2;

  typedef enum logic [4:0] {
    PIMD_IDLE  = 5'b00001,
    PIMD_FETCH = 5'b00010,
    PIMD_GEN   = 5'b00100,
    PIMD_XFER  = 5'b01000,
    PIMD_PAD   = 5'b10000
  } pimd_state_t;

  // vector divided by eight for each channel
  function automatic logic [4:0] vec_div8(input logic [3:0] ch);
    unique case (ch)
      4'h0: vec_div8 = 5'h02;
      4'h1: vec_div8 = 5'h03;
      4'h2: vec_div8 = 5'h04;
      4'h3: vec_div8 = 5'h05;
      4'h4: vec_div8 = 5'h06;
      4'h5: vec_div8 = 5'h07;
      4'h6: vec_div8 = 5'h08;
      4'h7: vec_div8 = 5'h09;
      4'h8: vec_div8 = 5'h0B;
      4'h9: vec_div8 = 5'h0E;
      4'hA: vec_div8 = 5'h0F;
      default: vec_div8 = 5'h00;
    endcase
  endfunction : vec_div8
endpackage : pimd_pkg

// ---- include/pimd_req_if.sv ----
// request latch bundle between the controller and its pending flip-flops
`timescale 1ns/1ps
interface pimd_req_if;
  logic [10:0] set;        // one-cycle source events
  logic [10:0] pend;       // pending request flip-flops
  logic        ack_v;      // vector read, clears ack_ch
  logic [3:0]  ack_ch;
  logic        clr_v;      // software clear write
  logic [4:0]  clr_code;   // written value, vector divided by eight
  logic        rx_read;    // receive buffer read
  modport latch (input set, ack_v, ack_ch, clr_v, clr_code, rx_read, output pend);
  modport ctrl  (output set, ack_v, ack_ch, clr_v, clr_code, rx_read, input pend);
endinterface : pimd_req_if

// ---- core/pimd_req_latch.sv ----
// pending request flip-flops with acknowledge, software and receive-read clears
`timescale 1ns/1ps
module pimd_req_latch (
  input  wire logic clock_in,
  input  wire logic sys_rst_in,
  pimd_req_if.latch rq
);
  logic [10:0] pend_r;
  logic [10:0] pend_nxt;

  // a source event in the same cycle as any clear keeps the request pending
  always_comb begin
    for (int i = 0; i < pimd_pkg::NCH; i++) begin
      logic clr;
      clr = 1'b0;
      if (rq.ack_v && rq.ack_ch == 4'(i)) begin
        clr = 1'b1;
      end
      if (4'(i) == pimd_pkg::CH_RX) begin
        if (rq.rx_read) begin
          clr = 1'b1;
        end
      end else if (rq.clr_v && rq.clr_code == pimd_pkg::vec_div8(4'(i))) begin
        clr = 1'b1;
      end
      pend_nxt[i] = rq.set[i] | (pend_r[i] & ~clr);
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pend_r <= 11'h000;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  assign rq.pend = pend_r;
endmodule : pimd_req_latch

// ---- core/pimd_core.sv ----
// prioritized interrupt controller with vectored and micro dma servicing sequencer
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - reset leaves every channel in vectored processing
// - nonmaskable always, maskable only with enable set
// - vector fetch shows dummy bus cycles
// - push pc and flags, clear enable, jump
// - vectored processing lasts twenty states
// - return instruction restores saved pc and flags
// - vector read clears that source's request
// - enable bit five, set and clear instructions
// - reset and any vectored acceptance clear enable; micro dma acceptance keeps it
// - enable acts after the following instruction
// - nonmaskable priorities one to three, fixed vectors
// - maskable priorities four to eleven, fixed vectors
// - micro dma only timers zero, one, serial
// - six byte block at ram base plus vector
// - highest pending priority presented first
// - no comparison with running handler priority
// - read, move, write back, count down
// - micro dma leaves cpu registers untouched
// - one or two bytes, full sixteen-bit addresses
// - mode byte selects length and address update
// - two bytes move low address first
// - non-final micro dma lasts forty-six states
// - software clear write drops matching request
// - per-channel maskable enables, cleared by reset
// - per-channel micro dma enables, cleared by reset
// - receive request clears by vector read or buffer read, not by software clear
module pimd_core (
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  input  wire logic        nmi_pin_in,
  input  wire logic        ext0_pin_in,
  input  wire logic        ext1_pin_in,
  input  wire logic        software_trap_instr_in,
  input  wire logic        watchdog_irq_in,
  input  wire logic        timer0_irq_in,
  input  wire logic        timer1_irq_in,
  input  wire logic        timer2_irq_in,
  input  wire logic        timer3_irq_in,
  input  wire logic        receive_done_irq_in,
  input  wire logic        transmit_done_irq_in,
  input  wire logic        rx_buffer_read_in,
  input  wire logic        req_clear_we_in,
  input  wire logic [7:0]  req_clear_code_in,
  input  wire logic        cfg_we_in,
  input  wire logic [7:0]  irq_enable_wdata_in,
  input  wire logic [3:0]  dma_enable_wdata_in,
  input  wire logic        enable_irq_instr_in,
  input  wire logic        disable_irq_instr_in,
  input  wire logic        instr_done_in,
  input  wire logic        return_from_irq_instr_in,
  input  wire logic [7:0]  popped_flags_in,
  input  wire logic [7:0]  mem_rdata_in,
  output logic             irq_enable_flipflop_out,
  output logic [10:0]      pending_out,
  output logic [7:0]       irq_enable_flags_out,
  output logic [3:0]       dma_enable_flags_out,
  output logic             busy_out,
  output logic             dummy_cycle_out,
  output logic             cpu_regs_hold_out,
  output logic             push_pc_af_out,
  output logic             load_pc_out,
  output logic [7:0]       vector_out,
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic [15:0]      mem_addr_out,
  output logic [7:0]       mem_wdata_out
);
  pimd_req_if rq ();

  pimd_pkg::pimd_state_t state_r;
  logic [6:0]  cyc_r;
  logic [3:0]  cur_ch_r;
  logic        iff_r;
  logic        ei_pend_r;
  logic [7:0]  irq_en_r;
  logic [3:0]  dma_en_r;
  logic [2:0]  sync1_r;
  logic [2:0]  sync2_r;
  logic [2:0]  sync3_r;
  logic [3:0]  op_r;
  logic [1:0]  ph_r;
  logic [7:0]  param_r [pimd_pkg::PB_BYTES];
  logic [7:0]  buf_r;
  logic [7:0]  vector_r;
  logic        mem_req_r;
  logic        mem_we_r;
  logic [15:0] mem_addr_r;
  logic [7:0]  mem_wdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: an edge counts once the second and third stage differ
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sync3_r <= 3'h0;
    end else begin
      sync1_r <= {ext1_pin_in, ext0_pin_in, nmi_pin_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  logic nmi_fall;
  logic ext0_rise;
  logic ext1_rise;
  assign nmi_fall  = sync3_r[0] & ~sync2_r[0];   // the pin requests on its falling edge
  assign ext0_rise = ~sync3_r[1] & sync2_r[1];
  assign ext1_rise = ~sync3_r[2] & sync2_r[2];

  // source events in priority order
  assign rq.set = {transmit_done_irq_in, receive_done_irq_in, ext1_rise, timer3_irq_in,
                   timer2_irq_in, timer1_irq_in, timer0_irq_in, ext0_rise,
                   watchdog_irq_in, nmi_fall, software_trap_instr_in};
  assign rq.clr_v    = req_clear_we_in;
  assign rq.clr_code = req_clear_code_in[4:0];
  assign rq.rx_read  = rx_buffer_read_in;

  pimd_req_latch u_latch (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .rq         (rq.latch)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // channel enables; both groups start cleared so servicing starts vectored
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      irq_en_r <= 8'h00;
      dma_en_r <= 4'h0;
    end else if (cfg_we_in) begin
      irq_en_r <= irq_enable_wdata_in;
      dma_en_r <= dma_enable_wdata_in;
    end
  end

  // micro dma enable of a channel, zero for channels without a parameter block
  function automatic logic dma_sel(input logic [3:0] ch, input logic [3:0] en);
    unique case (ch)
      pimd_pkg::CH_T0: dma_sel = en[0];
      pimd_pkg::CH_T1: dma_sel = en[1];
      pimd_pkg::CH_RX: dma_sel = en[2];
      pimd_pkg::CH_TX: dma_sel = en[3];
      default:         dma_sel = 1'b0;
    endcase
  endfunction : dma_sel

  ////////////////////////////////////////////////////////////////////////////////
  // eligibility and fixed priority; only pending requests are ranked, the
  // handler in progress is never part of the comparison
  logic [10:0] elig;
  logic        sel_v;
  logic [3:0]  sel_ch;
  always_comb begin
    elig = rq.pend;
    for (int i = 3; i < pimd_pkg::NCH; i++) begin
      elig[i] = rq.pend[i] & irq_en_r[i-3] & iff_r & ~ei_pend_r;
    end
    sel_v  = |elig;
    sel_ch = 4'h0;
    for (int i = pimd_pkg::NCH - 1; i >= 0; i--) begin
      if (elig[i]) begin
        sel_ch = 4'(i);
      end
    end
  end

  logic accept;
  logic fetch_end;
  logic gen_end;
  logic xfer_end;
  logic pad_end;
  assign accept    = (state_r == pimd_pkg::PIMD_IDLE) && instr_done_in && sel_v;
  assign fetch_end = (state_r == pimd_pkg::PIMD_FETCH) && (cyc_r == pimd_pkg::STATE_CYC - 7'h01);
  assign gen_end   = (state_r == pimd_pkg::PIMD_GEN) && (cyc_r == pimd_pkg::GEN_CYC - 7'h01);
  assign xfer_end  = (state_r == pimd_pkg::PIMD_XFER) && (op_r == pimd_pkg::OP_LAST) &&
                     (ph_r == pimd_pkg::PH_LAST);
  assign pad_end   = (state_r == pimd_pkg::PIMD_PAD) && (cyc_r == pimd_pkg::DMA_CYC - 7'h01);

  assign rq.ack_v  = fetch_end;
  assign rq.ack_ch = cur_ch_r;

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt enable flip-flop with delayed enable instruction
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      iff_r     <= 1'b0;
      ei_pend_r <= 1'b0;
    end else if (accept && !dma_sel(sel_ch, dma_en_r)) begin
      iff_r     <= 1'b0;
      ei_pend_r <= 1'b0;
    end else if (pad_end && param_r[pimd_pkg::PB_COUNT] == 8'h01) begin
      iff_r <= 1'b0;                                             // final transfer goes vectored
    end else if (disable_irq_instr_in) begin
      iff_r     <= 1'b0;
      ei_pend_r <= 1'b0;
    end else if (enable_irq_instr_in) begin
      ei_pend_r <= 1'b1;
    end else if (ei_pend_r && instr_done_in) begin
      iff_r     <= 1'b1;
      ei_pend_r <= 1'b0;
    end else if (return_from_irq_instr_in) begin
      iff_r <= popped_flags_in[pimd_pkg::IFF_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // servicing sequencer; cycle count runs from acceptance
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_r  <= pimd_pkg::PIMD_IDLE;
      cyc_r    <= 7'h00;
      cur_ch_r <= 4'h0;
      vector_r <= 8'h00;
    end else begin
      cyc_r <= cyc_r + 7'h01;
      unique case (state_r)
        pimd_pkg::PIMD_IDLE: begin
          cyc_r <= 7'h00;
          if (accept) begin
            state_r  <= pimd_pkg::PIMD_FETCH;
            cur_ch_r <= sel_ch;
          end
        end
        pimd_pkg::PIMD_FETCH: begin
          if (fetch_end) begin
            vector_r <= {pimd_pkg::vec_div8(cur_ch_r), 3'h0};
            state_r  <= dma_sel(cur_ch_r, dma_en_r) ? pimd_pkg::PIMD_XFER
                                                    : pimd_pkg::PIMD_GEN;
          end
        end
        pimd_pkg::PIMD_GEN: begin
          if (gen_end) begin
            state_r <= pimd_pkg::PIMD_IDLE;
          end
        end
        pimd_pkg::PIMD_XFER: begin
          if (xfer_end) begin
            state_r <= pimd_pkg::PIMD_PAD;
          end
        end
        pimd_pkg::PIMD_PAD: begin
          if (pad_end) begin
            if (param_r[pimd_pkg::PB_COUNT] == 8'h01) begin
              state_r <= pimd_pkg::PIMD_GEN;
              cyc_r   <= pimd_pkg::STATE_CYC;
            end else begin
              state_r <= pimd_pkg::PIMD_IDLE;
            end
          end
        end
      endcase
    end
  end

  // cpu handshakes of vectored processing
  assign dummy_cycle_out   = (state_r == pimd_pkg::PIMD_FETCH);
  assign push_pc_af_out    = (state_r == pimd_pkg::PIMD_GEN) &&
                             (cyc_r == pimd_pkg::STATE_CYC);
  assign load_pc_out       = gen_end;
  assign busy_out          = (state_r != pimd_pkg::PIMD_IDLE);
  // registers stay frozen through the transfer, only memory moves
  assign cpu_regs_hold_out = (state_r == pimd_pkg::PIMD_XFER) ||
                             (state_r == pimd_pkg::PIMD_PAD);

  ////////////////////////////////////////////////////////////////////////////////
  // micro dma addressing
  logic [15:0] pb_base;
  logic [15:0] dst;
  logic [15:0] src;
  logic [15:0] step;
  logic [15:0] dst_upd;
  logic [15:0] src_upd;
  logic        two_byte;
  logic [1:0]  upd;
  always_comb begin
    pb_base  = pimd_pkg::RAM_BASE + {8'h00, vector_r};
    dst      = {param_r[pimd_pkg::PB_DST_HI], param_r[pimd_pkg::PB_DST_LO]};
    src      = {param_r[pimd_pkg::PB_SRC_HI], param_r[pimd_pkg::PB_SRC_LO]};
    two_byte = param_r[pimd_pkg::PB_MODE][pimd_pkg::MODE_LEN_BIT];
    upd      = param_r[pimd_pkg::PB_MODE][1:0];
    step     = two_byte ? 16'h0002 : 16'h0001;
    dst_upd  = dst;
    src_upd  = src;
    unique case (upd)
      pimd_pkg::UPD_FIX:  dst_upd = dst;
      pimd_pkg::UPD_DINC: dst_upd = dst + step;
      pimd_pkg::UPD_SINC: src_upd = src + step;
      pimd_pkg::UPD_SDEC: src_upd = src - step;
    endcase
  end

  // at most one memory operation per op step: issue, present, capture
  logic        op_act;
  logic        op_we;
  logic [15:0] op_addr;
  logic [7:0]  op_wdata;
  always_comb begin
    op_act   = 1'b1;
    op_we    = 1'b0;
    op_addr  = pb_base + {12'h000, op_r};
    op_wdata = 8'h00;
    if (op_r >= pimd_pkg::OP_WBACK) begin
      op_we = 1'b1;
      op_addr = pb_base + {12'h000, op_r - pimd_pkg::OP_WBACK};
      unique case (3'(op_r - pimd_pkg::OP_WBACK))
        pimd_pkg::PB_COUNT:  op_wdata = param_r[pimd_pkg::PB_COUNT] - 8'h01;
        pimd_pkg::PB_DST_LO: op_wdata = dst_upd[7:0];
        pimd_pkg::PB_DST_HI: op_wdata = dst_upd[15:8];
        pimd_pkg::PB_SRC_LO: op_wdata = src_upd[7:0];
        default:             op_wdata = src_upd[15:8];
      endcase
    end else if (op_r >= pimd_pkg::OP_MOVE) begin
      op_act   = !op_r[3] || two_byte;
      op_we    = op_r[0];
      op_addr  = (op_r[0] ? dst : src) + {15'h0000, op_r[3]};
      op_wdata = buf_r;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      op_r        <= 4'h0;
      ph_r        <= 2'h0;
      buf_r       <= 8'h00;
      mem_req_r   <= 1'b0;
      mem_we_r    <= 1'b0;
      mem_addr_r  <= 16'h0000;
      mem_wdata_r <= 8'h00;
      for (int i = 0; i < pimd_pkg::PB_BYTES; i++) begin
        param_r[i] <= 8'h00;
      end
    end else if (state_r == pimd_pkg::PIMD_XFER) begin
      mem_req_r <= (ph_r == 2'h0) && op_act;
      mem_we_r  <= (ph_r == 2'h0) && op_act && op_we;
      if (ph_r == 2'h0) begin
        mem_addr_r  <= op_addr;
        mem_wdata_r <= op_wdata;
      end
      if (ph_r == pimd_pkg::PH_LAST) begin
        ph_r <= 2'h0;
        op_r <= op_r + 4'h1;
        if (op_r < pimd_pkg::OP_MOVE) begin
          param_r[op_r[2:0]] <= mem_rdata_in;
        end else if (op_act && !op_we && op_r < pimd_pkg::OP_WBACK) begin
          buf_r <= mem_rdata_in;
        end
      end else begin
        ph_r <= ph_r + 2'h1;
      end
    end else begin
      op_r      <= 4'h0;
      ph_r      <= 2'h0;
      mem_req_r <= 1'b0;
      mem_we_r  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign irq_enable_flipflop_out = iff_r;
  assign pending_out             = rq.pend;
  assign irq_enable_flags_out    = irq_en_r;
  assign dma_enable_flags_out    = dma_en_r;
  assign vector_out              = vector_r;
  assign mem_req_out             = mem_req_r;
  assign mem_we_out              = mem_we_r;
  assign mem_addr_out            = mem_addr_r;
  assign mem_wdata_out           = mem_wdata_r;
endmodule : pimd_core

// ---- verification/pimd_props.sv ----
// concurrent checks on the ports of the interrupt and micro dma controller
`timescale 1ns/1ps
module pimd_props (
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  input wire logic        instr_done_in,
  input wire logic        disable_irq_instr_in,
  input wire logic        return_from_irq_instr_in,
  input wire logic        irq_enable_flipflop_out,
  input wire logic [10:0] pending_out,
  input wire logic [7:0]  irq_enable_flags_out,
  input wire logic [3:0]  dma_enable_flags_out,
  input wire logic        busy_out,
  input wire logic        dummy_cycle_out,
  input wire logic        cpu_regs_hold_out,
  input wire logic        push_pc_af_out,
  input wire logic        load_pc_out,
  input wire logic        mem_req_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  logic [7:0] busy_cnt_r;
  // length of the current service, so a service can be timed without a long repetition
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !busy_out) busy_cnt_r <= 8'h00;
    else busy_cnt_r <= busy_cnt_r + 8'h01;
  end
  property p_fetch; $rose(busy_out) |-> dummy_cycle_out [*2] ##1 !dummy_cycle_out; endproperty
  a_fetch: assert property (p_fetch)
    else $error("vector fetch is not one state of dummy cycles");
  property p_dummy_bus; dummy_cycle_out |-> !mem_req_out; endproperty
  a_dummy_bus: assert property (p_dummy_bus)
    else $error("memory access during vector fetch");
  property p_push_iff; push_pc_af_out |-> !irq_enable_flipflop_out; endproperty
  a_push_iff: assert property (p_push_iff)
    else $error("enable flip-flop still set while saving context");
  property p_gen_len; $rose(busy_out) ##2 push_pc_af_out |-> ##37 load_pc_out ##1 !busy_out;
  endproperty
  a_gen_len: assert property (p_gen_len)
    else $error("vectored service length wrong");
  property p_dma_regs; mem_req_out |-> cpu_regs_hold_out && busy_out; endproperty
  a_dma_regs: assert property (p_dma_regs)
    else $error("memory transfer without cpu register hold");
  property p_dma_len; $fell(busy_out) && !$past(load_pc_out) |-> busy_cnt_r == 8'h5C; endproperty
  a_dma_len: assert property (p_dma_len)
    else $error("micro dma service length wrong");
  property p_en_delay;
    $rose(irq_enable_flipflop_out) |-> $past(instr_done_in) || $past(return_from_irq_instr_in);
  endproperty
  a_en_delay: assert property (p_en_delay)
    else $error("enable flip-flop set off an instruction boundary");
  property p_dis; disable_irq_instr_in |=> !irq_enable_flipflop_out; endproperty
  a_dis: assert property (p_dis)
    else $error("disable instruction left enable set");
  property p_reset;
    $fell(sys_rst_in) |-> pending_out == 11'h000 && irq_enable_flags_out == 8'h00
      && dma_enable_flags_out == 4'h0 && !irq_enable_flipflop_out;
  endproperty
  a_reset: assert property (p_reset)
    else $error("state not cleared by reset");
endmodule : pimd_props
bind pimd_core pimd_props u_props (.clock_in, .sys_rst_in, .instr_done_in,
  .disable_irq_instr_in, .return_from_irq_instr_in, .irq_enable_flipflop_out, .pending_out,
  .irq_enable_flags_out, .dma_enable_flags_out, .busy_out, .dummy_cycle_out,
  .cpu_regs_hold_out, .push_pc_af_out, .load_pc_out, .mem_req_out);

// ---- verification/pimd_mem_model.sv ----
// memory partner: byte array answering reads in the cycle after the request
`timescale 1ns/1ps
module pimd_mem_model (
  input  wire logic        clock_in,
  input  wire logic        mem_req_in,
  input  wire logic        mem_we_in,
  input  wire logic [15:0] mem_addr_in,
  input  wire logic [7:0]  mem_wdata_in,
  output logic      [7:0]  mem_rdata_out
);
  logic [7:0]  mem [0:65535];
  initial mem_rdata_out = 8'h5A;
  // data shows only in its answer cycle; inverted otherwise so a late capture never matches
  always @(posedge clock_in) begin
    if (mem_req_in && mem_we_in) mem[mem_addr_in] <= mem_wdata_in;
    mem_rdata_out <= (mem_req_in && !mem_we_in) ? mem[mem_addr_in] : ~mem_rdata_out;
  end
endmodule : pimd_mem_model

// ---- verification/tb_top.sv ----
// self-checking bench for the interrupt and micro dma controller
`timescale 1ns/1ps
module tb_top;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [10:0] src = 11'h000;
  logic rxrd = 0, clr_we = 0, cfg_we = 0, en_p = 0, dis_p = 0, idone = 0, ret_p = 0, gen;
  logic [7:0] clr_code = 8'h00, ien = 8'h00, flags = 8'h00, rdata, mwdata, vout;
  logic [3:0] den = 4'h0, ch;
  logic [15:0] dst, sa, pb, maddr;
  logic [10:0] pend;
  logic ien_ff, busy, loadpc, mreq, mwe;
  logic [7:0] vec [0:10] = '{8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'h40, 8'h48, 8'h58,
                             8'h70, 8'h78};
  logic [3:0] dch [0:3] = '{4'h4, 4'h5, 4'h9, 4'hA};
  int n_errors = 0, checks_done = 0, md, ln;
  always #50 clock_in = ~clock_in;
  pimd_core dut (.clock_in, .sys_rst_in, .nmi_pin_in(!src[1]), .ext0_pin_in(src[3]),
    .ext1_pin_in(src[8]), .software_trap_instr_in(src[0]), .watchdog_irq_in(src[2]),
    .timer0_irq_in(src[4]), .timer1_irq_in(src[5]), .timer2_irq_in(src[6]),
    .timer3_irq_in(src[7]), .receive_done_irq_in(src[9]), .transmit_done_irq_in(src[10]),
    .rx_buffer_read_in(rxrd), .req_clear_we_in(clr_we), .req_clear_code_in(clr_code),
    .cfg_we_in(cfg_we), .irq_enable_wdata_in(ien), .dma_enable_wdata_in(den),
    .enable_irq_instr_in(en_p), .disable_irq_instr_in(dis_p), .instr_done_in(idone),
    .return_from_irq_instr_in(ret_p), .popped_flags_in(flags), .mem_rdata_in(rdata),
    .irq_enable_flipflop_out(ien_ff), .pending_out(pend), .irq_enable_flags_out(),
    .dma_enable_flags_out(), .busy_out(busy), .dummy_cycle_out(), .cpu_regs_hold_out(),
    .push_pc_af_out(), .load_pc_out(loadpc), .vector_out(vout), .mem_req_out(mreq),
    .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwdata));
  pimd_mem_model mm (.clock_in, .mem_req_in(mreq), .mem_we_in(mwe), .mem_addr_in(maddr),
    .mem_wdata_in(mwdata), .mem_rdata_out(rdata));
  // every task starts and ends just after a falling edge
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask : tick
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic step;
    idone = 1'b1;
    tick(1);
    idone = 1'b0;
    tick(1);
  endtask : step
  task automatic cfg(input logic [7:0] a, input logic [3:0] b);
    {ien, den, cfg_we} = {a, b, 1'b1};
    tick(1);
    cfg_we = 1'b0;
  endtask : cfg
  task automatic clr(input logic [7:0] c);
    {clr_code, clr_we} = {c, 1'b1};
    tick(1);
    clr_we = 1'b0;
    tick(1);
  endtask : clr
  task automatic enable;
    en_p = 1'b1;
    tick(1);
    en_p = 1'b0;
  endtask : enable
  // boundary, then follow any service to its end; a hang is cut after 400 cycles
  task automatic run;
    step;
    gen = 1'b0;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
      if (loadpc === 1'b1) gen = 1'b1;
      tick(1);
    end
    if (busy !== 1'b0) begin
      n_errors++;
      complete_run;
    end
  endtask : run
  task automatic complete_run;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial begin
    tick(20);
    sys_rst_in = 1'b0;
    tick(2);
    cmp({pend, ien_ff}, 0);
    // all eleven sources at once, served one by one in fixed order
    src = 11'h7FF;
    tick(1);
    src = '0;
    tick(6);
    cmp(pend, 16'h07FF);
    for (int k = 0; k < 11; k++) begin
      if (k == 3) begin
        run;
        cmp(pend, 16'h07F8);
        cfg(8'hFF, 4'h0);
      end
      if (k > 2) begin
        enable;
        cmp(ien_ff, 0);
        step;
        cmp({busy, ien_ff}, 1);
      end
      run;
      cmp(vout, vec[k]);
      cmp({pend[k], ien_ff}, 0);
    end
    // software clear drops a timer request but not the receive request
    src = 11'h240;
    tick(1);
    src = '0;
    clr(8'h08);
    clr(8'h0E);
    cmp(pend, 16'h0200);
    rxrd = 1'b1;
    tick(1);
    rxrd = 1'b0;
    tick(1);
    cmp(pend, 0);
    {flags, ret_p} = {8'h20, 1'b1};
    tick(2);
    ret_p = 1'b0;
    cmp(ien_ff, 1);
    dis_p = 1'b1;
    tick(1);
    dis_p = 1'b0;
    tick(1);
    cmp(ien_ff, 0);
    // every transfer mode, rotating over the four dma channels; the last count runs out
    cfg(8'hFF, 4'hF);
    for (int m = 0; m < 8; m++) begin
      {ch, md, ln} = {dch[m % 4], m % 4, m / 4 + 1};
      pb = pimd_pkg::RAM_BASE + 16'(vec[ch]);
      sa = 16'h2000 + 16'(m * 16);
      dst = 16'h4000 + 16'(m * 16);
      {mm.mem[pb + 2], mm.mem[pb + 1], mm.mem[pb + 4], mm.mem[pb + 3]} = {dst, sa};
      {mm.mem[pb], mm.mem[pb + 5]} = {(m == 7) ? 8'h01 : 8'h02, 8'(m)};
      {mm.mem[sa], mm.mem[sa + 1], mm.mem[dst + 1]} = {8'hA0 + 8'(m), 8'hC3, 8'hEE};
      enable;
      step;
      src = 11'h001 << ch;
      tick(1);
      src = '0;
      run;
      cmp(mm.mem[dst], 8'hA0 + 8'(m));
      cmp(mm.mem[dst + 1], (m > 3) ? 8'hC3 : 8'hEE);
      cmp(mm.mem[pb], (m == 7) ? 8'h00 : 8'h01);
      cmp({mm.mem[pb + 2], mm.mem[pb + 1]}, dst + 16'((md == 1) ? ln : 0));
      cmp({mm.mem[pb + 4], mm.mem[pb + 3]}, sa + 16'((md == 2) ? ln : (md == 3) ? -ln : 0));
      cmp({gen, ien_ff}, (m == 7) ? 2'b10 : 2'b01);
    end
    complete_run;
  end
endmodule : tb_top
